// ---- wake_timer_power_cycle_control.sv ----
// Wake-up timer, timer resync, receiver timing and power-up delay of the radio.
// Assumes register accesses arrive as decoded byte strobes and all inputs are mclk-synchronous.
//
// Behaviour
// [R1] Auto-wake bit lets timer wrap wake device
// [R2] Single-shot wakes once until period rewritten
// [R3] Transmit resync at sync word or end
// [R4] Receive resync at sync word or end
// [R5] Address hit clears timer, CRC optional
// [R6] Broadcast end clears timer, CRC optional
// [R7] CRC qualification gates every reception clear
// [R8] Timer count readable high then low byte
// [R9] Writes set period; timer wraps there
// [R10] Idle counts PLL clock, sleeps count crystal
// [R11] Receiver timeout after value*8+1 symbol clocks
// [R12] Receiver settles delay+1 symbol clocks first
// [R13] Transceiver waits 4*delay symbols after wake
// [R14] Edge-select bit picks serial output edge
// [R15] Auto-flush faulty packets unless disabled
// [R16] Host waits frame end before FIFO reads
// [R17] Three disable bits turn off resources
// [R18] Symbol clock source bit selects external pin
// [R19] Crystal source bit selects external pin
// [R20] Crystal output bit drives crystal pin
// [R21] Calibration trims reset, load from NVM
// [R22] Sleep depth codes select clock source
// [R23] Receiver timeout flag, cleared on read
// [R24] Crystal timer flag set at zero
// [R25] Either period byte write re-arms one-shot
// [R26] Period applies once both bytes written
`include "wake_timer_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module wake_timer_power_cycle_control
   import wake_timer_pkg::*;
#(
   parameter int TIMER_W = 16
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [1:0] sleep_depth,
   input wire logic asleep,
   input wire logic int_pll_clk,
   input wire logic ext_pll_clk,
   input wire logic int_ext_crystal_clock_pin,
   input wire logic ext_crystal_clock_pin_in,
   output logic ext_crystal_clock_pin_out,
   output logic ext_crystal_clock_pin_oe,
   input wire logic tx_sync_sent,
   input wire logic tx_done,
   input wire logic rx_sync_seen,
   input wire logic rx_done,
   input wire logic rx_addr_match,
   input wire logic rx_broadcast,
   input wire logic rx_crc_ok,
   input wire logic rx_bad_packet,
   input wire logic rx_start,
   input wire logic rx_detect,
   input wire logic wake_done,
   input wire logic rx_timeout_flag_rd,
   input wire logic crystal_timer_flag_rd,
   input wire logic nvm_cal_load,
   input wire logic [7:0] nvm_cal_byte,
   output logic wake_req,
   output logic [TIMER_W-1:0] wake_timer_value,
   output logic rx_settling,
   output logic rx_listening,
   output logic rx_timeout_flag,
   output logic crystal_timer_flag,
   output logic rx_fifo_flush,
   output logic trx_power_en,
   output logic serial_out_edge_select,
   output logic rx_autoflush_disable,
   output logic core_supply_gate_disable,
   output logic converter_disable,
   output logic synth_disable,
   output logic symbol_clock_source,
   output logic crystal_clock_source,
   output logic crystal_clock_output_en,
   output logic sym_clk_sel,
   output logic ext_crystal_clock_pin_sel,
   output logic reserved_cal_bit,
   output logic [2:0] osc_resistor_trim,
   output logic [3:0] vref_trim
);

   // Register storage
   // Period bytes are kept apart from the applied period so a single byte write is held back
   logic [7:0] cfg_r;
   logic [TIMER_W-1:0] sleep_period_r;
   logic [7:0] period_hi_r;
   logic [7:0] period_lo_r;
   logic hi_written_r;
   logic lo_written_r;
   logic [7:0] rxto_hi_r;
   logic [7:0] rxto_lo_r;
   logic [7:0] trx_pu_r;
   logic [7:0] cal_r;
   logic [7:0] dis_r;
   logic armed_r;
   logic [1:0] clk_prev_r;
   logic rx_to_r;
   logic xo_flag_r;
   logic wake_r;
   logic flush_r;
   rx_state_type rx_state_r;
   rx_state_type rx_state_nxt;
   logic [15:0] rx_cnt_r;
   logic [15:0] rx_cnt_nxt;
   logic [9:0] pu_cnt_r;
   logic pu_busy_r;
   logic pu_ready_r;

   // Address decode
   wire wr_cfg = reg_wr && (reg_addr == `ADDR_WAKE_CFG);
   wire wr_hi = reg_wr && (reg_addr == `ADDR_PERIOD_HI);
   wire wr_lo = reg_wr && (reg_addr == `ADDR_PERIOD_LO);
   wire wr_rxto_hi = reg_wr && (reg_addr == `ADDR_RXTO_HI);
   wire wr_rxto_lo = reg_wr && (reg_addr == `ADDR_RXTO_LO);
   wire wr_trx_pu = reg_wr && (reg_addr == `ADDR_TRX_PU);
   wire wr_cal = reg_wr && (reg_addr == `ADDR_CAL);
   wire wr_dis = reg_wr && (reg_addr == `ADDR_DIS_CLK);

   // Clock selection; the crystal pin is read as the source whenever selected, even while it is driven out
   // The slow clocks are sampled as levels by mclk, so each high and each low phase
   // must last at least one mclk period or a tick is lost
   wire xtal_src = dis_r[`B_XTAL_SRC];
   wire sym_src = dis_r[`B_SYM_SRC];
   wire sym_level = sym_src ? ext_pll_clk : int_pll_clk; // [R18]
   wire xtal_level = xtal_src ? ext_crystal_clock_pin_in : int_ext_crystal_clock_pin; // [R19]
   wire sym_tick = sym_level && !clk_prev_r[0];
   wire xtal_tick = xtal_level && !clk_prev_r[1];

   // Idle codes 00 and 10 count the PLL clock, shallow and deep count the crystal
   wire depth_sleep = (sleep_depth == `DEPTH_SHALLOW) || (sleep_depth == `DEPTH_DEEP); // [R22]
   wire timer_tick = depth_sleep ? xtal_tick : sym_tick; // [R10]

   // Resync sources; reception clears need a good CRC whenever qualification is on
   // A resync that meets a wrap still lets the wrap raise its flag and its wake
   wire end_sel = cfg_r[`B_END_SEL];
   wire crc_gate = !cfg_r[`B_NEEDS_CRC] || rx_crc_ok; // [R7]
   wire tx_sync_evt = cfg_r[`B_RESYNC_TX] && (end_sel ? tx_done : tx_sync_sent); // [R3]
   wire rx_sync_evt = cfg_r[`B_RESYNC_RX] && (end_sel ? rx_done : rx_sync_seen) && crc_gate; // [R4]
   wire addr_evt = cfg_r[`B_ADDR_HIT] && rx_done && rx_addr_match && crc_gate; // [R5]
   wire bcast_evt = cfg_r[`B_BROADCAST] && rx_done && rx_broadcast && crc_gate; // [R6]
   wire resync = tx_sync_evt || rx_sync_evt || addr_evt || bcast_evt;

   // Wrap detection at the programmed period
   // Greater-or-equal, so a period lowered below the live count wraps on the next tick
   // instead of running round the whole count range first
   wire at_period = timer_tick && (wake_timer_value >= sleep_period_r); // [R9]
   wire timer_zero = at_period || resync;
   wire [TIMER_W-1:0] timer_inc = wake_timer_value + TIMER_W'(1);
   wire [TIMER_W-1:0] timer_nxt = timer_zero ? TIMER_W'(0) : (timer_tick ? timer_inc : wake_timer_value);
   wire may_wake = !cfg_r[`B_SINGLE_SHOT] || armed_r; // [R2]
   wire wake_nxt = at_period && asleep && cfg_r[`B_AUTO_WAKE] && may_wake; // [R1]

   // Period bytes pair up before they reach the comparator
   // Until both bytes have arrived the old period stays in force, so a half-written
   // value never triggers an early wrap
   wire hi_seen = hi_written_r || wr_hi;
   wire lo_seen = lo_written_r || wr_lo;
   wire period_commit = (wr_hi || wr_lo) && hi_seen && lo_seen; // [R26]
   wire [7:0] hi_byte = wr_hi ? reg_wdata : period_hi_r;
   wire [7:0] lo_byte = wr_lo ? reg_wdata : period_lo_r;

   // Receiver timing loads
   // Both counters end on the tick that finds them at zero, which gives the extra
   // symbol clock of the settle and timeout spans
   wire [11:0] rx_to_val = {rxto_hi_r, rxto_lo_r[7:4]};
   wire [15:0] rx_to_load = {1'b0, rx_to_val, 3'b000}; // [R11]
   wire [15:0] rx_settle_load = {12'h000, rxto_lo_r[3:0]}; // [R12]
   wire rx_cnt_done = (rx_cnt_r == `ZERO16);
   wire rx_expire = (rx_state_r == rx_listen) && sym_tick && rx_cnt_done && !rx_detect;
   wire [9:0] pu_load = {trx_pu_r, 2'b00}; // [R13]
   wire pu_start = wake_done || wake_r;

   // Read mux; reserved and unmapped addresses read as zero
   // The period addresses return the live count; the period itself is write-only
   logic [7:0] rdata_nxt;
   always_comb begin
      unique case (reg_addr)
         `ADDR_WAKE_CFG: rdata_nxt = cfg_r;
         `ADDR_PERIOD_HI: rdata_nxt = wake_timer_value[15:8]; // [R8]
         `ADDR_PERIOD_LO: rdata_nxt = wake_timer_value[7:0]; // [R8]
         `ADDR_RXTO_HI: rdata_nxt = rxto_hi_r;
         `ADDR_RXTO_LO: rdata_nxt = rxto_lo_r;
         `ADDR_TRX_PU: rdata_nxt = trx_pu_r;
         `ADDR_CAL: rdata_nxt = cal_r;
         `ADDR_DIS_CLK: rdata_nxt = dis_r;
         default: rdata_nxt = `ZERO8;
      endcase
   end

   // Receiver sequence: settle, then listen until packet or timeout
   // A start request outside rx_off is ignored
   always_comb begin
      rx_state_nxt = rx_state_r;
      rx_cnt_nxt = rx_cnt_r;
      unique case (rx_state_r)
         rx_off: begin
            if (rx_start) begin
               rx_state_nxt = rx_settle;
               rx_cnt_nxt = rx_settle_load; // [R12]
            end
         end
         rx_settle: begin
            if (sym_tick) begin
               if (rx_cnt_done) begin
                  rx_state_nxt = rx_listen;
                  rx_cnt_nxt = rx_to_load; // [R11]
               end else begin
                  rx_cnt_nxt = rx_cnt_r - `ONE16;
               end
            end
         end
         rx_listen: begin
            if (rx_detect || rx_expire) begin
               rx_state_nxt = rx_off; // [R11]
            end else if (sym_tick) begin
               rx_cnt_nxt = rx_cnt_r - `ONE16;
            end
         end
      endcase
   end

   // Register writes and reads
   // Read data is registered and holds until the next read strobe
   always_ff @(posedge mclk) begin
      if (reset) begin
         cfg_r <= `RST_WAKE_CFG;
         rxto_hi_r <= `RST_RXTO_HI;
         rxto_lo_r <= `RST_RXTO_LO;
         trx_pu_r <= `RST_TRX_PU;
         dis_r <= `RST_DIS_CLK;
         reg_rdata <= `ZERO8;
      end else if (clk_en) begin
         if (wr_cfg) cfg_r <= reg_wdata;
         if (wr_rxto_hi) rxto_hi_r <= reg_wdata;
         if (wr_rxto_lo) rxto_lo_r <= reg_wdata;
         if (wr_trx_pu) trx_pu_r <= reg_wdata;
         if (wr_dis) dis_r <= reg_wdata; // [R17]
         if (reg_rd) reg_rdata <= rdata_nxt;
      end
   end

   // Calibration byte: software write or factory value from NVM, software wins
   // A write is the newer intent of software, so it beats a load in the same cycle
   always_ff @(posedge mclk) begin
      if (reset) begin
         cal_r <= `RST_CAL;
      end else if (clk_en) begin
         if (wr_cal) cal_r <= reg_wdata; // [R21]
         else if (nvm_cal_load) cal_r <= nvm_cal_byte; // [R21]
      end
   end

   // Sleep period staging and one-shot arming
   // Reset leaves no byte pending and the one-shot armed
   always_ff @(posedge mclk) begin
      if (reset) begin
         sleep_period_r <= `RST_PERIOD;
         period_hi_r <= `RST_PERIOD_HI;
         period_lo_r <= `RST_PERIOD_LO;
         hi_written_r <= 1'b0;
         lo_written_r <= 1'b0;
         armed_r <= 1'b1;
      end else if (clk_en) begin
         if (wr_hi) period_hi_r <= reg_wdata;
         if (wr_lo) period_lo_r <= reg_wdata;
         hi_written_r <= hi_seen && !period_commit;
         lo_written_r <= lo_seen && !period_commit;
         if (period_commit) sleep_period_r <= {hi_byte, lo_byte}; // [R26]
         // A rewrite re-arms even if it lands on the wake cycle
         if (wr_hi || wr_lo) armed_r <= 1'b1; // [R25]
         else if (wake_nxt) armed_r <= 1'b0; // [R2]
      end
   end

   // Wake timer, edge history and wake pulse
   // The edge history freezes with clk_en, so a clock pulse that ends while frozen is dropped
   always_ff @(posedge mclk) begin
      if (reset) begin
         wake_timer_value <= `ZERO16;
         clk_prev_r <= 2'b00;
         wake_r <= 1'b0;
      end else if (clk_en) begin
         wake_timer_value <= timer_nxt; // [R9]
         clk_prev_r <= {xtal_level, sym_level};
         wake_r <= wake_nxt; // [R1]
      end
   end

   // Sticky flags: a new event beats a read clear in the same cycle
   // The flush pulse follows the faulty packet by one edge and lasts one cycle
   always_ff @(posedge mclk) begin
      if (reset) begin
         rx_to_r <= 1'b0;
         xo_flag_r <= 1'b0;
         flush_r <= 1'b0;
      end else if (clk_en) begin
         rx_to_r <= rx_expire || (rx_to_r && !rx_timeout_flag_rd); // [R23]
         xo_flag_r <= at_period || (xo_flag_r && !crystal_timer_flag_rd); // [R24]
         flush_r <= rx_bad_packet && !dis_r[`B_FLUSH_DIS]; // [R15]
      end
   end

   // Receiver sequencer state
   always_ff @(posedge mclk) begin
      if (reset) begin
         rx_state_r <= rx_off;
         rx_cnt_r <= `ZERO16;
      end else if (clk_en) begin
         rx_state_r <= rx_state_nxt;
         rx_cnt_r <= rx_cnt_nxt;
      end
   end

   // Power-up hold after wake; sleeping drops the transceiver again
   // A new wake restarts the hold from the full delay
   always_ff @(posedge mclk) begin
      if (reset) begin
         pu_cnt_r <= `ZERO10;
         pu_busy_r <= 1'b0;
         pu_ready_r <= 1'b0;
      end else if (clk_en) begin
         if (asleep && !pu_start) begin
            pu_busy_r <= 1'b0;
            pu_ready_r <= 1'b0;
         end else if (pu_start) begin
            pu_cnt_r <= pu_load; // [R13]
            pu_busy_r <= (pu_load != `ZERO10);
            pu_ready_r <= (pu_load == `ZERO10);
         end else if (pu_busy_r && sym_tick) begin
            if (pu_cnt_r == `ONE10) begin
               pu_busy_r <= 1'b0;
               pu_ready_r <= 1'b1; // [R13]
            end
            pu_cnt_r <= pu_cnt_r - `ONE10;
         end
      end
   end

   // Outputs straight from control state, except the crystal pin output, which follows the internal crystal input
   assign wake_req = wake_r;
   assign rx_timeout_flag = rx_to_r;
   assign crystal_timer_flag = xo_flag_r;
   assign rx_fifo_flush = flush_r;
   assign trx_power_en = pu_ready_r;
   assign rx_settling = (rx_state_r == rx_settle);
   assign rx_listening = (rx_state_r == rx_listen);
   assign serial_out_edge_select = dis_r[`B_EDGE_SEL]; // [R14]
   assign rx_autoflush_disable = dis_r[`B_FLUSH_DIS];
   assign core_supply_gate_disable = dis_r[`B_SUPPLY_DIS]; // [R17]
   assign converter_disable = dis_r[`B_CONV_DIS]; // [R17]
   assign synth_disable = dis_r[`B_SYNTH_DIS]; // [R17]
   assign symbol_clock_source = sym_src;
   assign crystal_clock_source = xtal_src;
   assign crystal_clock_output_en = dis_r[`B_XTAL_OUT];
   assign sym_clk_sel = sym_src; // [R18]
   assign ext_crystal_clock_pin_sel = xtal_src; // [R19]
   // Driving the pin while it is also the selected source would loop; software must not do both
   assign ext_crystal_clock_pin_out = int_ext_crystal_clock_pin; // [R20]
   assign ext_crystal_clock_pin_oe = dis_r[`B_XTAL_OUT]; // [R20]
   assign reserved_cal_bit = cal_r[7];
   assign osc_resistor_trim = cal_r[6:4]; // [R21]
   assign vref_trim = cal_r[3:0]; // [R21]

endmodule : wake_timer_power_cycle_control
`default_nettype wire

// ---- wake_timer_regs.svh ----
// Register addresses, field positions and reset values of the wake timer block.
// Assumes an 8-bit register address and 8-bit data from the serial front end.
`ifndef WAKE_TIMER_REGS_SVH
`define WAKE_TIMER_REGS_SVH
`define ADDR_WAKE_CFG 8'h05
`define ADDR_PERIOD_HI 8'h06
`define ADDR_PERIOD_LO 8'h07
`define ADDR_RXTO_HI 8'h08
`define ADDR_RXTO_LO 8'h09
`define ADDR_TRX_PU 8'h0a
`define ADDR_RSVD_B 8'h0b
`define ADDR_RSVD_C 8'h0c
`define ADDR_CAL 8'h0d
`define ADDR_DIS_CLK 8'h0e
`define RST_WAKE_CFG 8'h00
`define RST_PERIOD 16'h0800
`define RST_PERIOD_HI 8'h08
`define RST_PERIOD_LO 8'h00
`define RST_RXTO_HI 8'hff
`define RST_RXTO_LO 8'hf3
`define RST_TRX_PU 8'h00
`define RST_CAL 8'h2a
`define RST_DIS_CLK 8'h80
`define ZERO8 8'h00
`define ZERO16 16'h0000
`define ONE16 16'h0001
`define ZERO10 10'h000
`define ONE10 10'h001
// Field positions in the timer configuration register
`define B_AUTO_WAKE 7
`define B_SINGLE_SHOT 6
`define B_END_SEL 5
`define B_RESYNC_TX 4
`define B_RESYNC_RX 3
`define B_ADDR_HIT 2
`define B_BROADCAST 1
`define B_NEEDS_CRC 0
// Field positions in the disables and clock control register
`define B_EDGE_SEL 7
`define B_FLUSH_DIS 6
`define B_SUPPLY_DIS 5
`define B_CONV_DIS 4
`define B_SYNTH_DIS 3
`define B_SYM_SRC 2
`define B_XTAL_SRC 1
`define B_XTAL_OUT 0
// Sleep depth codes
`define DEPTH_SHALLOW 2'b01
`define DEPTH_DEEP 2'b11
`endif

// ---- wake_timer_pkg.sv ----
// Types shared by the wake timer block.
// Assumes the register header is included by the design file.
package wake_timer_pkg;
   typedef enum logic [1:0] {rx_off, rx_settle, rx_listen} rx_state_type;
endpackage : wake_timer_pkg

// ---- wake_timer_power_cycle_control_checker.sv ----
// Port checker of the wake timer block.
// Assumes one clock, mclk, and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module wake_timer_power_cycle_control_checker #(
   parameter int TIMER_W = 16
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic asleep,
   input wire logic rx_bad_packet,
   input wire logic rx_timeout_flag_rd,
   input wire logic rx_autoflush_disable,
   input wire logic wake_req,
   input wire logic [TIMER_W-1:0] wake_timer_value,
   input wire logic rx_settling,
   input wire logic rx_listening,
   input wire logic rx_timeout_flag,
   input wire logic crystal_timer_flag,
   input wire logic rx_fifo_flush
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   // Faulty packet while flushing is allowed
   sequence s_flushable;
      clk_en && rx_bad_packet && !rx_autoflush_disable;
   endsequence
   // Count back at zero with the flag raised at the same edge as the wake
   sequence s_wrapped;
      wake_timer_value == '0 && crystal_timer_flag;
   endsequence
   // Flush, wake and receiver outputs tied to their causes
   a_flush_after_bad:
      assert property (s_flushable |=> rx_fifo_flush) else $error("flush missing");
   a_flush_has_cause:
      assert property (rx_fifo_flush |-> $past(rx_bad_packet) && !$past(rx_autoflush_disable)) else $error("stray flush");
   a_wake_when_asleep:
      assert property (wake_req |-> $past(asleep)) else $error("wake while awake");
   a_wake_at_wrap:
      assert property (wake_req |-> s_wrapped) else $error("wake off wrap");
   a_count_steps:
      assert property ($changed(wake_timer_value) |-> wake_timer_value == '0 ||
         wake_timer_value == $past(wake_timer_value) + 1'b1) else $error("count jump");
   a_rxto_clear_read:
      assert property ($fell(rx_timeout_flag) |-> $past(rx_timeout_flag_rd)) else $error("flag lost");
   a_timeout_from_listen:
      assert property ($rose(rx_timeout_flag) |-> $past(rx_listening)) else $error("timeout not listening");
   a_listen_after_settle:
      assert property ($rose(rx_listening) |-> $past(rx_settling)) else $error("listen without settle");
endmodule : wake_timer_power_cycle_control_checker
bind wake_timer_power_cycle_control wake_timer_power_cycle_control_checker #(.TIMER_W(TIMER_W)) u_chk (
   .mclk(mclk), .reset(reset), .clk_en(clk_en), .asleep(asleep), .rx_bad_packet(rx_bad_packet),
   .rx_timeout_flag_rd(rx_timeout_flag_rd), .rx_autoflush_disable(rx_autoflush_disable), .wake_req(wake_req),
   .wake_timer_value(wake_timer_value), .rx_settling(rx_settling), .rx_listening(rx_listening),
   .rx_timeout_flag(rx_timeout_flag), .crystal_timer_flag(crystal_timer_flag), .rx_fifo_flush(rx_fifo_flush));
`default_nettype wire

// ---- wake_timer_host_model.sv ----
// Host side of the register port: byte writes and reads as one-cycle strobes.
// Assumes its tasks are called in turn from one bench process.
`timescale 1ns/10ps
`default_nettype none
module wake_timer_host_model (
   input wire logic mclk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   // Quiet bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // Byte write; idle bus then shows the inverse so stale data never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   // Byte read, data taken one edge after the strobe, only between frames
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge mclk);
      d = reg_rdata;
   endtask : rd
endmodule : wake_timer_host_model
`default_nettype wire

// ---- tb_wake_timer_power_cycle_control.sv ----
// Self-checking bench of the wake timer block.
// Assumes the host model issues every register cycle; the bench drives clocks and events.
`timescale 1ns/10ps
`default_nettype none
module tb_wake_timer_power_cycle_control;
   localparam logic [79:0] RV = 80'h0000_00ff_f300_0000_2a80;
   localparam logic [15:0] RS [9] = '{16'h1001, 16'h1010, 16'h3011, 16'h0821, 16'h2831,
      16'h0433, 16'h0532, 16'h033d, 16'h2930};
   logic mclk, reset, clk_en, asleep, wreq, sett, lis, rxto, xtf, fl, trx, rw, rr;
   logic [1:0] sleep_depth;
   logic [3:0] ck, vref;
   logic [2:0] lv, osc;
   logic [4:0] ox;
   logic [10:0] ev;
   logic [7:0] nvm, rdv, ra, wd, rdat;
   wire [7:0] dis;
   logic [15:0] cnt, e;
   int errors, cmp_count, wakes;
   wake_timer_host_model u_host (.mclk(mclk), .reg_addr(ra), .reg_wdata(wd), .reg_wr(rw), .reg_rd(rr),
      .reg_rdata(rdat));
   wake_timer_power_cycle_control u_dut (.mclk(mclk), .reset(reset), .clk_en(clk_en), .reg_addr(ra),
      .reg_wdata(wd), .reg_wr(rw), .reg_rd(rr), .reg_rdata(rdat), .sleep_depth(sleep_depth), .asleep(asleep),
      .int_pll_clk(ck[0]), .ext_pll_clk(ck[1]), .int_ext_crystal_clock_pin(ck[2]), .ext_crystal_clock_pin_in(ck[3]),
      .ext_crystal_clock_pin_out(ox[0]), .ext_crystal_clock_pin_oe(ox[1]), .tx_sync_sent(ev[0]), .tx_done(ev[1]),
      .rx_sync_seen(ev[2]), .rx_done(ev[3]), .rx_addr_match(lv[0]), .rx_broadcast(lv[1]), .rx_crc_ok(lv[2]),
      .rx_bad_packet(ev[4]), .rx_start(ev[5]), .rx_detect(ev[6]), .wake_done(ev[7]),
      .rx_timeout_flag_rd(ev[8]), .crystal_timer_flag_rd(ev[9]), .nvm_cal_load(ev[10]), .nvm_cal_byte(nvm),
      .wake_req(wreq), .wake_timer_value(cnt), .rx_settling(sett), .rx_listening(lis), .rx_timeout_flag(rxto),
      .crystal_timer_flag(xtf), .rx_fifo_flush(fl), .trx_power_en(trx), .serial_out_edge_select(dis[7]),
      .rx_autoflush_disable(dis[6]), .core_supply_gate_disable(dis[5]), .converter_disable(dis[4]),
      .synth_disable(dis[3]), .symbol_clock_source(dis[2]), .crystal_clock_source(dis[1]),
      .crystal_clock_output_en(dis[0]), .sym_clk_sel(ox[2]), .ext_crystal_clock_pin_sel(ox[3]), .reserved_cal_bit(ox[4]),
      .osc_resistor_trim(osc), .vref_trim(vref));
   // Compare and tally; case equality so an unknown never passes
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [7:0] x);
      u_host.rd(a, rdv);
      chk({8'h00, rdv}, {8'h00, x});
   endtask : rdc
   // Rising edges on clock line i, levels held three cycles so the edge detector sees each
   task automatic tk(input int i, input int n);
      repeat (n) begin
         @(posedge mclk);
         ck[i] <= 1'b1;
         repeat (3) @(posedge mclk);
         ck[i] <= 1'b0;
         repeat (3) @(posedge mclk);
      end
   endtask : tk
   // One-cycle event pulse; returns once its effect has landed
   task automatic pu(input int i);
      @(posedge mclk);
      ev[i] <= 1'b1;
      @(posedge mclk);
      ev[i] <= 1'b0;
      @(posedge mclk);
   endtask : pu
   task automatic wrap_up();
      $display("Mismatches %0d, comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : wrap_up
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Wake pulses are tallied so a missed or doubled wake shows in the totals
   always @(posedge mclk)
      if (wreq === 1'b1) wakes++;
   // Watchdog far beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      wrap_up();
   end
   initial begin
      reset = 1'b1;
      clk_en = 1'b1;
      asleep = 1'b0;
      sleep_depth = 2'b01;
      ck = '0;
      ev = '0;
      lv = '0;
      nvm = 8'h00;
      errors = 0;
      cmp_count = 0;
      wakes = 0;
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      // Reset values, a reserved place and an unmapped one
      for (int a = 5; a < 15; a++) rdc(a[7:0], RV[8*(14-a) +: 8]);
      chk({8'h00, dis}, 16'h0080);
      chk({9'h000, osc, vref}, 16'h002a);
      chk({11'h000, ox}, 16'h0000);
      u_host.wr(8'h0b, 8'h55);
      u_host.wr(8'h0e, 8'h7f);
      // Internal crystal high while the pin is the source, so no tick, but it must reach the pin
      ck[2] <= 1'b1;
      rdc(8'h0b, 8'h00);
      rdc(8'h20, 8'h00);
      chk({8'h00, dis}, 16'h007f);
      chk({11'h000, ox}, 16'h000f);
      ck[2] <= 1'b0;
      u_host.wr(8'h0e, 8'h80);
      // Crystal-timed period of two; the third tick wraps and wakes
      asleep <= 1'b1;
      u_host.wr(8'h06, 8'h00);
      u_host.wr(8'h07, 8'h02);
      u_host.wr(8'h05, 8'h80);
      tk(2, 2);
      rdc(8'h06, 8'h00);
      rdc(8'h07, 8'h02);
      tk(2, 1);
      chk({wakes[14:0], xtf}, 16'h0003);
      pu(9);
      chk({cnt[14:0], xtf}, 16'h0000);
      // Idle counts the symbol clock only; deep sleep the crystal
      sleep_depth <= 2'b00;
      tk(2, 2);
      tk(0, 1);
      chk(cnt, 16'h0001);
      sleep_depth <= 2'b11;
      tk(2, 1);
      chk(cnt, 16'h0002);
      // Single shot: one wake per rewrite, either byte re-arms
      u_host.wr(8'h05, 8'hc0);
      u_host.wr(8'h07, 8'h02);
      tk(2, 4);
      chk(wakes[15:0], 16'h0002);
      u_host.wr(8'h06, 8'h00);
      tk(2, 3);
      chk(wakes[15:0], 16'h0003);
      u_host.wr(8'h05, 8'h00);
      tk(2, 3);
      chk(wakes[15:0], 16'h0003);
      // Resync table: config, event line, {crc, broadcast, address}, clears
      asleep <= 1'b0;
      u_host.wr(8'h06, 8'h00);
      u_host.wr(8'h07, 8'h10);
      e = 16'h0000;
      for (int k = 0; k < 9; k++) begin
         u_host.wr(8'h05, RS[k][15:8]);
         tk(2, 1);
         lv <= RS[k][3:1];
         pu(RS[k][7:4]);
         e = RS[k][0] ? 16'h0000 : e + 16'h0001;
         chk(cnt, e);
      end
      // Frozen clock enable: a crystal tick and a register write are both dropped
      clk_en <= 1'b0;
      tk(2, 1);
      u_host.wr(8'h0a, 8'h07);
      clk_en <= 1'b1;
      chk(cnt, e);
      rdc(8'h0a, 8'h00);
      // Receiver: settle one tick, listen nine, time out
      u_host.wr(8'h08, 8'h00);
      u_host.wr(8'h09, 8'h10);
      pu(5);
      tk(0, 1);
      chk({14'h0000, sett, lis}, 16'h0001);
      tk(0, 8);
      chk({14'h0000, lis, rxto}, 16'h0002);
      tk(0, 1);
      chk({14'h0000, lis, rxto}, 16'h0001);
      pu(8);
      pu(5);
      tk(0, 1);
      pu(6);
      chk({14'h0000, lis, rxto}, 16'h0000);
      // Power-up hold of four ticks after a wake
      u_host.wr(8'h0a, 8'h01);
      pu(7);
      tk(0, 3);
      chk({15'h0000, trx}, 16'h0000);
      tk(0, 1);
      chk({15'h0000, trx}, 16'h0001);
      // Faulty packets with flushing on then off; the checker judges the pulse
      pu(4);
      u_host.wr(8'h0e, 8'hc0);
      pu(4);
      nvm <= 8'hdb;
      pu(10);
      rdc(8'h0d, 8'hdb);
      chk({8'h00, ox[4], osc, vref}, 16'h00db);
      wrap_up();
   end
endmodule : tb_wake_timer_power_cycle_control
`default_nettype wire
